// >>> src/rtlc_tx_engine.sv
`timescale 1ns/1ps
// What this block does
// - Interrupt on chain end, halt, frame, error
// - Status block: code, field, list address
// - Command complete ends transmit, reports last list
// - Halt before any frame reports zero address
// - Command and frame complete never together
// - Frame complete after frame asking interrupt
// - Frame complete reports last frame's last list
// - List error sets cause bits, ends command
// - List error posted alone, lists untouched
// - Reserved completion bits written zero
// - Bad frame size flags cause bit 8
// - Frame above buffer threshold flags bit 9
// - Odd pointer on non-end list flags 10
// - Unexpected or missing frame start flags 11
// - Unauthorized access priority flags bit 12
// - Bad MAC class or attention flags 13
// - FC bit 0 set flags bit 14
// - Invalid frame start suspends chain silently
// - Valid request acts only when suspended
// - Only frame start status words rewritten
// - Odd alignment handled by single byte moves
// - Halt stops chain, purges, ignored when idle
module rtlc_tx_engine (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [rtlc_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host memory master, 16-bit words
  output logic mem_req,
  output logic mem_we,
  output logic [rtlc_pkg::ADDR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // Byte stream to the ring transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_abort,
  input wire logic tx_ready,
  // Completion notice
  output logic tx_irq
);
  import rtlc_pkg::*;

  rtlc_state_t state;
  logic [15:0] desc [DESC_WORDS];
  logic [2:0] widx;
  logic [1:0] hidx;
  logic [1:0] sidx;
  logic [ADDR_W-1:0] chain_addr;
  logic [ADDR_W-1:0] hsb_addr;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] last_addr;
  logic [ADDR_W-1:0] post_addr;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] hdr_addr;
  logic [ADDR_W-1:0] fwd;
  logic [31:0] cfg;
  logic [31:0] auth;
  logic [31:0] rd_mux;
  logic [15:0] fsize;
  logic [15:0] chk_fsize;
  logic [15:0] rem;
  logic [15:0] post_field;
  logic [15:0] last_field;
  logic [15:0] post_word;
  logic [15:0] err_field;
  logic [15:0] start_cs;
  logic [7:0] ac;
  logic [7:0] fc;
  logic [7:0] cls;
  logic [6:0] cause;
  logic [16:0] acc_sum;
  logic [16:0] sum_now;
  logic any_sent;
  logic exp_start;
  logic mid_frame;
  logic frame_int;
  logic post_ret;
  logic halt_pend;
  logic apb_go;
  logic start_req;
  logic halt_req;
  logic valid_req;
  logic cs_valid;
  logic cs_start;
  logic cs_end;
  logic dchk_ok;
  logic post_last;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == OFS_CTRL || a == OFS_CHAIN || a == OFS_HSB ||
             a == OFS_CFG || a == OFS_AUTH || a == OFS_STAT;
  endfunction

  // Even host address carries the high byte
  function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                           input logic odd);
    pick_byte = odd ? w[7:0] : w[15:8];
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_go = psel && penable && pready;
  assign start_req = apb_go && pwrite && paddr == OFS_CTRL &&
                     pwdata[CTL_START];
  assign halt_req = apb_go && pwrite && paddr == OFS_CTRL &&
                    pwdata[CTL_HALT];
  assign valid_req = apb_go && pwrite && paddr == OFS_CTRL &&
                     pwdata[CTL_VALID];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFS_CHAIN)
      rd_mux = 32'(chain_addr);
    else if (paddr == OFS_HSB)
      rd_mux = 32'(hsb_addr);
    else if (paddr == OFS_CFG)
      rd_mux = cfg;
    else if (paddr == OFS_AUTH)
      rd_mux = auth;
    else if (paddr == OFS_STAT)
      rd_mux = {last_field, 8'h00, any_sent, halt_pend,
                state == ST_SUSP, state != ST_IDLE, state};
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= !mapped(paddr);
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chain_addr <= '0;
      hsb_addr <= '0;
      cfg <= CFG_RST;
      auth <= AUTH_RST;
    end
    else if (apb_go && pwrite)
    begin
      if (paddr == OFS_CHAIN)
        chain_addr <= pwdata[ADDR_W-1:0];
      if (paddr == OFS_HSB)
        hsb_addr <= pwdata[ADDR_W-1:0];
      if (paddr == OFS_CFG)
        cfg <= pwdata;
      if (paddr == OFS_AUTH)
        auth <= pwdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      halt_pend <= 1'b0;
    else if (state == ST_IDLE)
      halt_pend <= 1'b0;
    else if (halt_req)
      halt_pend <= 1'b1;
  end

  // ----------------------------------------
  // Descriptor checks
  // ----------------------------------------
  assign fwd = {desc[0][7:0], desc[1]};
  assign cs_valid = desc[DW_DSW][CS_VALID];
  assign cs_start = desc[DW_DSW][CS_START];
  assign cs_end = desc[DW_DSW][CS_END];
  assign chk_fsize = exp_start ? desc[DW_SIZE] : fsize;
  assign sum_now = (exp_start ? 17'h00000 : acc_sum) +
                   17'(desc[DW_COUNT]);
  assign hdr_addr = ptr + ADDR_W'(hidx);
  assign err_field = TCF_LIST | (16'(cause) << TC_CAUSE_LSB);
  assign dchk_ok = state == ST_DCHK && !halt_pend && cause == 7'h00 &&
                   !(exp_start && cs_start && !cs_valid);
  assign post_last = state == ST_POST && mem_req && mem_ack &&
                     sidx == 2'd3;

  rtlc_err_check u_chk (
    .chk_desc(state == ST_DCHK),
    .chk_hdr(state == ST_HCHK),
    .exp_start(exp_start),
    .cs_start(cs_start),
    .cs_end(cs_end),
    .fwd_odd(fwd[0]),
    .fsize(chk_fsize),
    .size_sum(sum_now),
    .ac(ac),
    .fc(fc),
    .cls(cls[3:0]),
    .buf_size(cfg[15:0]),
    .max_cnt(cfg[CFG_MAX_LSB +: 8]),
    .rif_len(auth[AUTH_RIF_LSB +: 8]),
    .auth_pri(cfg[CFG_PRI_LSB +: 3]),
    .class_mask(auth[15:0]),
    .cause(cause)
  );

  rtlc_size_acc u_acc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clr(dchk_ok && exp_start),
    .add(dchk_ok),
    .cnt(desc[DW_COUNT]),
    .sum(acc_sum)
  );

  always_comb
  begin
    unique case (sidx)
      2'd0: post_word = HSB_CODE;
      2'd1: post_word = post_field;
      2'd2: post_word = {8'h00, post_addr[23:16]};
      2'd3: post_word = post_addr[15:0];
    endcase
  end

  // ----------------------------------------
  // Chain walker
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      for (int i = 0; i < DESC_WORDS; i++)
        desc[i] <= 16'h0000;
      {widx, hidx, sidx} <= 7'h00;
      {cur_addr, start_addr, last_addr, post_addr, ptr} <= '0;
      {fsize, rem, post_field, last_field, start_cs} <= '0;
      {ac, fc, cls} <= 24'h000000;
      {any_sent, exp_start, mid_frame, frame_int, post_ret} <= 5'h00;
      {mem_req, mem_we, mem_addr, mem_wdata} <= '0;
      {tx_valid, tx_data, tx_last, tx_abort, tx_irq} <= '0;
    end
    else
    begin
      tx_irq <= 1'b0;
      tx_abort <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (start_req && !chain_addr[0])
          begin
            cur_addr <= chain_addr;
            widx <= 3'h0;
            exp_start <= 1'b1;
            any_sent <= 1'b0;
            last_addr <= '0;
            mid_frame <= 1'b0;
            state <= ST_DRD;
          end
        ST_DRD:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            desc[widx] <= mem_rdata;
            if (widx == DW_LAST)
              state <= ST_DCHK;
            else
              widx <= widx + 3'h1;
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= cur_addr + ADDR_W'({widx, 1'b0});
          end
        ST_DCHK:
          if (halt_pend)
          begin
            tx_abort <= mid_frame;
            post_field <= TCF_CMD;
            post_addr <= any_sent ? last_addr : '0;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else if (exp_start && cs_start && !cs_valid)
            state <= ST_SUSP;
          else if (cause != 7'h00)
          begin
            tx_abort <= mid_frame;
            post_field <= err_field;
            post_addr <= exp_start ? cur_addr : start_addr;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else
          begin
            if (exp_start)
            begin
              start_addr <= cur_addr;
              fsize <= desc[DW_SIZE];
              frame_int <= desc[DW_DSW][CS_INT];
              // Later lists overwrite desc; keep the start word
              start_cs <= desc[DW_DSW];
            end
            ptr <= {desc[5][7:0], desc[6]};
            rem <= desc[DW_COUNT];
            hidx <= 2'd0;
            state <= exp_start ? ST_HDR : ST_DATA_RD;
          end
        ST_SUSP:
          if (halt_pend)
          begin
            post_field <= TCF_CMD;
            post_addr <= any_sent ? last_addr : '0;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else if (valid_req)
          begin
            widx <= 3'h0;
            state <= ST_DRD;
          end
        ST_HDR:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            if (hidx == 2'd0)
              ac <= pick_byte(mem_rdata, hdr_addr[0]);
            else if (hidx == 2'd1)
              fc <= pick_byte(mem_rdata, hdr_addr[0]);
            else
              cls <= pick_byte(mem_rdata, hdr_addr[0]);
            if (hidx == 2'd2)
              state <= ST_HCHK;
            else
              hidx <= hidx + 2'd1;
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {hdr_addr[ADDR_W-1:1], 1'b0};
          end
        ST_HCHK:
          if (cause != 7'h00)
          begin
            post_field <= err_field;
            post_addr <= start_addr;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else
            state <= ST_DATA_RD;
        ST_DATA_RD:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            tx_data <= pick_byte(mem_rdata, ptr[0]);
            tx_valid <= 1'b1;
            tx_last <= cs_end && rem == 16'h0001;
            state <= ST_DATA_OUT;
          end
          else if (!mem_req && halt_pend)
          begin
            tx_abort <= mid_frame;
            post_field <= TCF_CMD;
            post_addr <= any_sent ? last_addr : '0;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else if (!mem_req && rem == 16'h0000)
            state <= ST_NEXT;
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {ptr[ADDR_W-1:1], 1'b0};
          end
        ST_DATA_OUT:
          // one byte at a time from any alignment
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            mid_frame <= 1'b1;
            ptr <= ptr + 24'h000001;
            rem <= rem - 16'h0001;
            state <= ST_DATA_RD;
          end
        ST_NEXT:
          if (cs_end)
            state <= ST_DSW;
          else
          begin
            cur_addr <= fwd;
            exp_start <= 1'b0;
            widx <= 3'h0;
            state <= ST_DRD;
          end
        ST_DSW:
          // rewrite the frame start status word only
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            mid_frame <= 1'b0;
            any_sent <= 1'b1;
            last_addr <= cur_addr;
            if (frame_int)
            begin
              post_field <= TCF_FRAME;
              post_addr <= cur_addr;
              post_ret <= 1'b1;
              sidx <= 2'd0;
              state <= ST_POST;
            end
            else
              state <= ST_ADV;
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= start_addr + DSW_OFS;
            mem_wdata <= (start_cs & CS_KEEP) | CS_DONE;
          end
        ST_ADV:
          // command complete at chain end or halt
          if (halt_pend || fwd[0])
          begin
            post_field <= TCF_CMD;
            post_addr <= last_addr;
            post_ret <= 1'b0;
            sidx <= 2'd0;
            state <= ST_POST;
          end
          else
          begin
            cur_addr <= fwd;
            exp_start <= 1'b1;
            widx <= 3'h0;
            state <= ST_DRD;
          end
        ST_POST:
          if (mem_req && mem_ack)
          begin
            mem_req <= 1'b0;
            sidx <= sidx + 2'd1;
            if (sidx == 2'd3)
            begin
              tx_irq <= 1'b1;
              last_field <= post_field;
              state <= post_ret ? ST_ADV : ST_IDLE;
            end
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= hsb_addr + ADDR_W'({sidx, 1'b0});
            mem_wdata <= post_word;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_HSB_CODE:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx == 2'd0) |->
    (mem_we && mem_wdata == HSB_CODE && mem_addr == hsb_addr))
    else $error("status block code word wrong");
  AST_CC_FC_APART:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx == 2'd1) |->
    (mem_wdata & (TCF_CMD | TCF_FRAME)) != (TCF_CMD | TCF_FRAME))
    else $error("command and frame complete together");
  AST_RSVD_ZERO:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx == 2'd1) |->
    (mem_wdata & TC_RSVD) == 16'h0000)
    else $error("reserved completion bit set");
  AST_LIST_ALONE:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx == 2'd1 &&
     (mem_wdata & TCF_LIST) != 16'h0000) |->
    (mem_wdata & (TCF_CMD | TCF_FRAME)) == 16'h0000)
    else $error("list error mixed with completion");
  AST_IRQ_AFTER_POST:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_irq |-> $past(post_last))
    else $error("interrupt without finished status block");
  AST_SUSP_SILENT:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_SUSP && !halt_pend && !valid_req) |=>
    (state == ST_SUSP && !mem_req && !tx_irq))
    else $error("suspend not silent");
  AST_VALID_IGNORED:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_IDLE && valid_req && !start_req) |=>
    state == ST_IDLE)
    else $error("valid request acted on while idle");
  AST_HALT_ADDR0:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx[1] && !any_sent &&
     post_field == TCF_CMD) |-> mem_wdata == 16'h0000)
    else $error("halt before any frame gives nonzero address");
  AST_DSW_START:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_DSW && mem_req) |->
    (mem_we && mem_addr == start_addr + DSW_OFS))
    else $error("status word write off the frame start");
  AST_FRAME_ADDR:
  assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == ST_POST && mem_req && sidx == 2'd3 &&
     post_field == TCF_FRAME) |-> mem_wdata == last_addr[15:0])
    else $error("frame complete address not last list");
endmodule

// >>> src/rtlc_pkg.sv
package rtlc_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int APB_AW = 8;
  // ----------------------------------------
  // Register offsets, fields and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAIN = 8'h04;
  localparam logic [7:0] OFS_HSB = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  localparam logic [7:0] OFS_AUTH = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam int CTL_START = 0;
  localparam int CTL_HALT = 1;
  localparam int CTL_VALID = 2;
  localparam int CFG_MAX_LSB = 16;
  localparam int CFG_PRI_LSB = 24;
  localparam int AUTH_RIF_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h0304_0200;
  localparam logic [31:0] AUTH_RST = 32'h0000_fffe;
  // ----------------------------------------
  // Descriptor layout, 16-bit words
  // ----------------------------------------
  localparam int DESC_WORDS = 7;
  localparam logic [2:0] DW_DSW = 3'h2;
  localparam logic [2:0] DW_SIZE = 3'h3;
  localparam logic [2:0] DW_COUNT = 3'h4;
  localparam logic [2:0] DW_LAST = 3'h6;
  localparam logic [23:0] DSW_OFS = 24'h000004;
  // Bit 0 of a status word is its msb
  localparam int CS_VALID = 15;
  localparam int CS_START = 13;
  localparam int CS_END = 12;
  localparam int CS_INT = 11;
  localparam logic [15:0] CS_KEEP = 16'h1b00;
  localparam logic [15:0] CS_DONE = 16'h6000;
  // ----------------------------------------
  // Status block and completion field
  // ----------------------------------------
  localparam logic [15:0] HSB_CODE = 16'h0004;
  localparam logic [15:0] TCF_CMD = 16'h8000;
  localparam logic [15:0] TCF_FRAME = 16'h4000;
  localparam logic [15:0] TCF_LIST = 16'h2000;
  localparam logic [15:0] TC_RSVD = 16'h1f01;
  localparam int TC_CAUSE_LSB = 1;
  localparam logic [16:0] MIN_HDR = 17'h0000f;
  localparam logic [15:0] THR_SUB = 16'h0008;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DRD = 4'b0001,
    ST_DCHK = 4'b0010,
    ST_SUSP = 4'b0011,
    ST_HDR = 4'b0100,
    ST_HCHK = 4'b0101,
    ST_DATA_RD = 4'b0110,
    ST_DATA_OUT = 4'b0111,
    ST_NEXT = 4'b1000,
    ST_DSW = 4'b1001,
    ST_ADV = 4'b1010,
    ST_POST = 4'b1011
  } rtlc_state_t;
endpackage

// >>> src/rtlc_err_check.sv
`timescale 1ns/1ps
module rtlc_err_check (
  // Which checks apply now
  input wire logic chk_desc,
  input wire logic chk_hdr,
  // Descriptor
  input wire logic exp_start,
  input wire logic cs_start,
  input wire logic cs_end,
  input wire logic fwd_odd,
  input wire logic [15:0] fsize,
  input wire logic [16:0] size_sum,
  // Frame header bytes
  input wire logic [7:0] ac,
  input wire logic [7:0] fc,
  input wire logic [3:0] cls,
  // Open-time limits
  input wire logic [15:0] buf_size,
  input wire logic [7:0] max_cnt,
  input wire logic [7:0] rif_len,
  input wire logic [2:0] auth_pri,
  input wire logic [15:0] class_mask,
  // Cause, frame size error in the msb
  output logic [6:0] cause
);
  import rtlc_pkg::*;

  logic [23:0] thr;
  logic is_mac;

  assign thr = 24'(buf_size - THR_SUB) * 24'(max_cnt);
  assign is_mac = fc[7:6] == 2'b00;

  always_comb
  begin
    cause = 7'h00;
    if (chk_desc)
    begin
      if (exp_start && (fsize == 16'h0000 ||
          17'(fsize) < MIN_HDR + 17'(rif_len)))
        cause[6] = 1'b1;
      if (cs_end && size_sum != 17'(fsize))
        cause[6] = 1'b1;
      if (exp_start && 24'(fsize) > thr)
        cause[5] = 1'b1;
      if (!cs_end && fwd_odd)
        cause[4] = 1'b1;
      if (cs_start != exp_start)
        cause[3] = 1'b1;
    end
    if (chk_hdr)
    begin
      if (ac[7:5] > auth_pri)
        cause[2] = 1'b1;
      if (is_mac && (cls == 4'h0 || !class_mask[cls] ||
          fc[5:0] > 6'h01))
        cause[1] = 1'b1;
      if (fc[7])
        cause[0] = 1'b1;
    end
  end
endmodule

// >>> src/rtlc_size_acc.sv
`timescale 1ns/1ps
module rtlc_size_acc (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic clr,
  input wire logic add,
  input wire logic [15:0] cnt,
  // Running byte sum of the frame
  output logic [16:0] sum
);
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sum <= 17'h00000;
    else if (clr)
      sum <= add ? 17'(cnt) : 17'h00000;
    else if (add)
      sum <= sum + 17'(cnt);
  end
endmodule

// >>> testbench/rtlc_host_mem.sv
`timescale 1ns/1ps
module rtlc_host_mem (
  // Clock
  input wire logic core_clk,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:255];
  logic [1:0] wait_cnt;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 16'h5a5a;
    wait_cnt = 2'h0;
  end
  // ----------------------------------------
  // Slow answer; stale read data toggles
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (wait_cnt == 2'h2)
      begin
        mem_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (mem_we)
          mem[mem_addr[8:1]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[8:1]];
      end
      else
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import rtlc_pkg::*;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] lastb;
  logic err;
  logic mem_req, mem_we, mem_ack, tx_valid, tx_last, tx_abort, tx_irq;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  int miscompares, n_checks, nbytes, nlast, naborts, cyc;
  rtlc_tx_engine DUT (.core_clk(core_clk), .arst_n(arst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_abort(tx_abort),
    .tx_ready(1'b1), .tx_irq(tx_irq));
  rtlc_host_mem u_mem (.core_clk(core_clk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq(output int ok);
    ok = 0;
    repeat (1000) @(posedge core_clk) if (tx_irq === 1'b1) ok++;
  endtask
  // Host side: one list, odd forward pointer, never self-linked
  task automatic run(input logic [15:0] cs, input logic [15:0] sz,
                     output int ok);
    u_mem.mem[8'h20] = 16'h0000;
    u_mem.mem[8'h21] = 16'h0001;
    u_mem.mem[8'h22] = cs;
    u_mem.mem[8'h23] = sz;
    u_mem.mem[8'h24] = 16'h0010;
    u_mem.mem[8'h25] = 16'h0000;
    u_mem.mem[8'h26] = 16'h0100;
    for (int i = 0; i < 8; i++)
      u_mem.mem[8'h80 + i] = i == 0 ? 16'h0040 : 16'h0102;
    // Stale status block must not pass for a fresh one
    for (int i = 0; i < 4; i++)
      u_mem.mem[8'h40 + i] = 16'hffff;
    {nbytes, nlast, naborts} = '0;
    apb(1'b1, OFS_CHAIN, 32'h40);
    apb(1'b1, OFS_HSB, 32'h80);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_irq(ok);
  endtask
  always @(posedge core_clk)
  begin
    if (tx_valid === 1'b1)
      nbytes++;
    if (tx_valid === 1'b1 && tx_last === 1'b1)
      nlast++;
    if (tx_valid === 1'b1 && tx_last === 1'b1)
      lastb = tx_data;
    if (tx_abort === 1'b1)
      naborts++;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", CFG_RST, rd);
    chk("cfg err", 0, err);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, OFS_CTRL, 32'h6);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("idle busy", 0, rd[4]);
    chk("idle halt", 0, rd[6]);
    $display("test regs done");
  endtask
  task automatic t_good;
    int ok;
    run(16'hb000, 16'h0010, ok);
    chk("irq", 1, ok);
    chk("bytes", 16, nbytes);
    chk("last", 1, nlast);
    chk("last byte", 8'h02, lastb);
    chk("abort", 0, naborts);
    chk("code", HSB_CODE, u_mem.mem[8'h40]);
    chk("field", TCF_CMD, u_mem.mem[8'h41]);
    chk("addr", 32'h40, {u_mem.mem[8'h42], u_mem.mem[8'h43]});
    chk("lstat", 16'h7000, u_mem.mem[8'h22]);
    $display("test good frame done");
  endtask
  task automatic t_size;
    int ok;
    run(16'hb000, 16'h0000, ok);
    chk("err irq", 1, ok);
    chk("err abort", 0, naborts);
    chk("err field", 16'h2080, u_mem.mem[8'h41]);
    chk("err addr", 16'h0040, u_mem.mem[8'h43]);
    chk("err lstat", 16'hb000, u_mem.mem[8'h22]);
    chk("no bytes", 0, nbytes);
    $display("test size error done");
  endtask
  task automatic t_frame;
    int ok;
    run(16'hb800, 16'h0010, ok);
    chk("irqs", 2, ok);
    chk("fi field", TCF_CMD, u_mem.mem[8'h41]);
    chk("fi lstat", 16'h7800, u_mem.mem[8'h22]);
    $display("test frame interrupt done");
  endtask
  task automatic t_susp;
    int ok;
    run(16'h3000, 16'h0010, ok);
    chk("silent", 0, ok);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("suspended", 1, rd[5]);
    u_mem.mem[8'h22] = 16'hb000;
    apb(1'b1, OFS_CTRL, 32'h4);
    wait_irq(ok);
    chk("resumed", 1, ok);
    chk("res addr", 16'h0040, u_mem.mem[8'h43]);
    run(16'h3000, 16'h0010, ok);
    apb(1'b1, OFS_CTRL, 32'h2);
    wait_irq(ok);
    chk("halt irq", 1, ok);
    chk("halt field", TCF_CMD, u_mem.mem[8'h41]);
    chk("halt addr", 32'h0, {u_mem.mem[8'h42], u_mem.mem[8'h43]});
    $display("test suspend and halt done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well above the short runs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {miscompares, n_checks, cyc} = '0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_good();
    t_size();
    t_frame();
    t_susp();
    final_report();
  end
endmodule
